//--- hdl/suc_top.sv
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module suc_top (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_cs,
  input  wire logic                       i_rd,
  input  wire logic                       i_wr,
  input  wire logic [suc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [suc_pkg::DATA_W-1:0] i_wdata,
  output logic      [suc_pkg::DATA_W-1:0] o_rdata,
  output logic                            o_drive_disable_out,
  output logic                            o_irq,
  input  wire logic                       i_serial_in,
  output logic                            o_serial_out,
  output logic                            o_baud_out,
  input  wire logic                       i_clear_to_send_in_n,
  input  wire logic                       i_peer_set_ready_in_n,
  input  wire logic                       i_phone_call_alert_in_n,
  input  wire logic                       i_carrier_detect_in_n,
  output logic                            o_request_to_send_out_n,
  output logic                            o_terminal_ready_out_n
);
  import suc_pkg::*;

  logic [4:0]        sync1_ff, sync2_ff;
  logic [7:0]        lcr_ff, nxt_lcr, scr_ff, nxt_scr;
  logic [3:0]        ier_ff, nxt_ier;
  logic [4:0]        mcr_ff, nxt_mcr;
  logic [DIV_W-1:0]  div_ff, nxt_div;
  logic [7:0]        rbr_ff, nxt_rbr, thr_ff, nxt_thr;
  logic              thr_empty_ff, nxt_thr_empty, thre_int_ff, nxt_thre_int;
  logic              dr_ff, nxt_dr, oe_ff, nxt_oe, pe_ff, nxt_pe;
  logic              fe_ff, nxt_fe, bi_ff, nxt_bi;
  logic [3:0]        mprev_ff, nxt_mprev, mdelta_ff, nxt_mdelta;
  logic [7:0]        rdata_ff, nxt_rdata;
  logic              drive_disable_out_ff, irq_ff, sout_ff, rts_n_ff, dtr_n_ff;
  suc_ser_t          rx_st_ff, nxt_rx_st;
  logic [CNT_W-1:0]  rx_cnt_ff, nxt_rx_cnt;
  logic [2:0]        rx_bit_ff, nxt_rx_bit;
  logic [7:0]        rx_sh_ff, nxt_rx_sh;
  logic              rx_p_ff, nxt_rx_p;
  logic              rd_en, wr_en, dlab, loop, tick16, txd, tx_busy, tx_load, rxd;
  logic              rx_done, rx_pe, rx_fe, rx_bi, rx_mid, rx_end, line_any;
  logic [3:0]        mnow, mchg;
  logic [7:0]        iid, lsr, msr, rd_val;

  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction

  // Pins pass two flops first: {dcd, ri, dsr, cts, rx}
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1_ff <= 5'h1f;
      sync2_ff <= 5'h1f;
    end else begin
      sync1_ff <= {i_carrier_detect_in_n, i_phone_call_alert_in_n,
                   i_peer_set_ready_in_n, i_clear_to_send_in_n, i_serial_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign rd_en = i_cs && i_rd;
  assign wr_en = i_cs && i_wr;
  assign dlab  = lcr_ff[LC_DLAB];
  assign loop  = mcr_ff[MC_LOOP];
  assign rxd   = loop ? txd : sync2_ff[0];
  assign tx_load = !thr_empty_ff && !tx_busy;

  suc_baud u_baud (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_divisor  (div_ff),
    .o_tick16   (tick16),
    .o_baud_out (o_baud_out)
  );

  suc_tx u_tx (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_tick16 (tick16),
    .i_load   (tx_load),
    .i_data   (thr_ff),
    .i_lcr    (lcr_ff),
    .o_txd    (txd),
    .o_busy   (tx_busy)
  );

  // Receiver
  always_comb begin
    nxt_rx_st  = rx_st_ff;
    nxt_rx_cnt = tick16 ? rx_cnt_ff + 6'h01 : rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh  = rx_sh_ff;
    nxt_rx_p   = rx_p_ff;
    rx_done    = 1'b0;
    rx_pe      = lcr_ff[LC_PEN] && (rx_p_ff != par_bit(rx_sh_ff, lcr_ff));
    rx_fe      = !rxd;
    rx_bi      = !rxd && (rx_sh_ff == ZERO_8) && !(lcr_ff[LC_PEN] && rx_p_ff);
    rx_mid     = tick16 && (rx_cnt_ff + 6'h01 == TICKS_HALF);
    rx_end     = tick16 && (rx_cnt_ff + 6'h01 == TICKS_BIT);
    case (rx_st_ff)
      SER_IDLE: begin
        nxt_rx_cnt = '0;
        if (!rxd) begin
          nxt_rx_st = SER_START;
          nxt_rx_sh = ZERO_8;
        end
      end
      SER_START: begin
        if (rx_mid) begin
          nxt_rx_cnt = '0;
          nxt_rx_bit = 3'h0;
          nxt_rx_st  = rxd ? SER_IDLE : SER_DATA;
        end
      end
      SER_DATA: begin
        if (rx_end) begin
          nxt_rx_cnt = '0;
          nxt_rx_sh[rx_bit_ff] = rxd;
          nxt_rx_bit = rx_bit_ff + 3'h1;
          if (rx_bit_ff == last_bit(lcr_ff[1:0])) begin
            nxt_rx_st = lcr_ff[LC_PEN] ? SER_PAR : SER_STOP;
          end
        end
      end
      SER_PAR: begin
        if (rx_end) begin
          nxt_rx_cnt = '0;
          nxt_rx_p   = rxd;
          nxt_rx_st  = SER_STOP;
        end
      end
      SER_STOP: begin
        if (rx_end) begin
          rx_done   = 1'b1;
          nxt_rx_st = SER_IDLE;
        end
      end
      default: nxt_rx_st = SER_IDLE;
    endcase
  end

  // Status views and interrupt identification
  always_comb begin
    mnow = loop ? {mcr_ff[MC_OUT2], mcr_ff[MC_OUT1], mcr_ff[MC_DTR], mcr_ff[MC_RTS]}
                : ~sync2_ff[4:1];
    mchg = {mnow[3] ^ mprev_ff[3], mprev_ff[2] && !mnow[2],
            mnow[1:0] ^ mprev_ff[1:0]};
    line_any = oe_ff || pe_ff || fe_ff || bi_ff;
    lsr = {1'b0, thr_empty_ff && !tx_busy, thr_empty_ff, bi_ff, fe_ff, pe_ff, oe_ff, dr_ff};
    msr = {mnow, mdelta_ff};
    if (ier_ff[IE_LS] && line_any)          iid = IID_LINE;
    else if (ier_ff[IE_RX] && dr_ff)        iid = IID_RXDAT;
    else if (ier_ff[IE_TX] && thre_int_ff)  iid = IID_THRE;
    else if (ier_ff[IE_MS] && |mdelta_ff)   iid = IID_MODEM;
    else                                    iid = IID_NONE;
    case (i_addr)
      ADR_HOLD:       rd_val = dlab ? div_ff[7:0] : rbr_ff;
      ADR_INT_EN:     rd_val = dlab ? div_ff[15:8] : {4'h0, ier_ff};
      ADR_INT_ID:     rd_val = iid;
      ADR_LINE_CTRL:  rd_val = lcr_ff;
      ADR_MODEM_CTRL: rd_val = {3'h0, mcr_ff};
      ADR_LINE_STAT:  rd_val = lsr;
      ADR_MODEM_STAT: rd_val = msr;
      default:        rd_val = scr_ff;
    endcase
  end

  // Register file: load, writes, read clears, then hardware sets
  always_comb begin
    nxt_lcr = lcr_ff;  nxt_scr = scr_ff;  nxt_ier = ier_ff;  nxt_mcr = mcr_ff;
    nxt_div = div_ff;  nxt_rbr = rbr_ff;  nxt_thr = thr_ff;
    nxt_thr_empty = thr_empty_ff || tx_load;
    nxt_thre_int = thre_int_ff;
    nxt_dr = dr_ff;  nxt_oe = oe_ff;  nxt_pe = pe_ff;  nxt_fe = fe_ff;  nxt_bi = bi_ff;
    nxt_mprev = mnow;
    nxt_mdelta = mdelta_ff;
    nxt_rdata = rdata_ff;
    if (wr_en) begin
      case (i_addr)
        ADR_HOLD: begin
          if (dlab) begin
            nxt_div[7:0] = i_wdata;
          end else begin
            nxt_thr = i_wdata;
            nxt_thr_empty = 1'b0;
            nxt_thre_int = 1'b0;
          end
        end
        ADR_INT_EN: begin
          if (dlab) nxt_div[15:8] = i_wdata;
          else nxt_ier = i_wdata[3:0];
        end
        ADR_LINE_CTRL:  nxt_lcr = i_wdata;
        ADR_MODEM_CTRL: nxt_mcr = i_wdata[4:0];
        ADR_SCRATCH:    nxt_scr = i_wdata;
        default: ;
      endcase
    end
    if (rd_en) begin
      nxt_rdata = rd_val;
      if (at(i_addr, ADR_HOLD) && !dlab) nxt_dr = 1'b0;
      if (at(i_addr, ADR_INT_ID) && iid == IID_THRE) nxt_thre_int = 1'b0;
      if (at(i_addr, ADR_LINE_STAT)) begin
        nxt_oe = 1'b0;  nxt_pe = 1'b0;  nxt_fe = 1'b0;  nxt_bi = 1'b0;
      end
      if (at(i_addr, ADR_MODEM_STAT)) nxt_mdelta = 4'h0;
    end
    if ((tx_load && !(wr_en && at(i_addr, ADR_HOLD) && !dlab)) ||
        (wr_en && at(i_addr, ADR_INT_EN) && !dlab && i_wdata[IE_TX] && thr_empty_ff))
      nxt_thre_int = 1'b1;
    if (rx_done) begin
      nxt_rbr = rx_sh_ff;
      nxt_dr  = 1'b1;
      if (dr_ff && !(rd_en && at(i_addr, ADR_HOLD) && !dlab)) nxt_oe = 1'b1;
      if (rx_pe) nxt_pe = 1'b1;
      if (rx_fe) nxt_fe = 1'b1;
      if (rx_bi) nxt_bi = 1'b1;
    end
    nxt_mdelta = nxt_mdelta | mchg;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lcr_ff <= ZERO_8;  scr_ff <= ZERO_8;  ier_ff <= 4'h0;  mcr_ff <= 5'h00;
      div_ff <= DIV_RST;
      rbr_ff <= ZERO_8;  thr_ff <= ZERO_8;
      thr_empty_ff <= 1'b1;  thre_int_ff <= 1'b0;
      dr_ff <= 1'b0;  oe_ff <= 1'b0;  pe_ff <= 1'b0;  fe_ff <= 1'b0;  bi_ff <= 1'b0;
      mprev_ff <= 4'h0;  mdelta_ff <= 4'h0;  rdata_ff <= ZERO_8;
      drive_disable_out_ff <= 1'b1;  irq_ff <= 1'b0;  sout_ff <= 1'b1;
      rts_n_ff <= 1'b1;  dtr_n_ff <= 1'b1;
      rx_st_ff <= SER_IDLE;  rx_cnt_ff <= '0;  rx_bit_ff <= 3'h0;
      rx_sh_ff <= ZERO_8;  rx_p_ff <= 1'b0;
    end else begin
      lcr_ff <= nxt_lcr;  scr_ff <= nxt_scr;  ier_ff <= nxt_ier;  mcr_ff <= nxt_mcr;
      div_ff <= nxt_div;
      rbr_ff <= nxt_rbr;  thr_ff <= nxt_thr;
      thr_empty_ff <= nxt_thr_empty;  thre_int_ff <= nxt_thre_int;
      dr_ff <= nxt_dr;  oe_ff <= nxt_oe;  pe_ff <= nxt_pe;  fe_ff <= nxt_fe;  bi_ff <= nxt_bi;
      mprev_ff <= nxt_mprev;  mdelta_ff <= nxt_mdelta;  rdata_ff <= nxt_rdata;
      drive_disable_out_ff <= !rd_en;
      irq_ff  <= (iid != IID_NONE);
      sout_ff <= loop || (txd && !lcr_ff[LC_BRK]);
      rts_n_ff <= loop || !mcr_ff[MC_RTS];
      dtr_n_ff <= loop || !mcr_ff[MC_DTR];
      rx_st_ff <= nxt_rx_st;  rx_cnt_ff <= nxt_rx_cnt;  rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;  rx_p_ff <= nxt_rx_p;
    end
  end

  assign o_rdata                 = rdata_ff;
  assign o_drive_disable_out     = drive_disable_out_ff;
  assign o_irq                   = irq_ff;
  assign o_serial_out            = sout_ff;
  assign o_request_to_send_out_n = rts_n_ff;
  assign o_terminal_ready_out_n  = dtr_n_ff;

  AST_DIV_RST: assert property (@(posedge i_clk) !i_rst_n |=> div_ff == DIV_RST)
    else $error("divisor not one after reset");
  AST_RDATA_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rd_en |=> $stable(o_rdata)) else $error("read data changed without a read");
  AST_RBR_READ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rd_en && at(i_addr, ADR_HOLD) && !dlab) |=>
      o_rdata == $past(rbr_ff) && (!dr_ff || $past(rx_done)))
    else $error("receive holding read wrong");
  AST_DRIVE_DISABLE_OUT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_en |=> !o_drive_disable_out ##1 (o_drive_disable_out || $past(rd_en)))
    else $error("drive disable wrong around read");
  AST_LINE_PRIO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ier_ff[IE_LS] && line_any) |-> iid == IID_LINE ##1 o_irq)
    else $error("line status not top priority");
  AST_IRQ_CAUSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ier_ff == 4'h0) ##1 (ier_ff == 4'h0) |-> !o_irq)
    else $error("interrupt with all sources disabled");
  AST_OVERRUN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rx_done && dr_ff && !rd_en) |=> oe_ff && dr_ff)
    else $error("overrun not flagged");
  AST_FALSE_START: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rx_st_ff == SER_START && rx_mid && rxd) |=> rx_st_ff == SER_IDLE)
    else $error("false start bit accepted");
  AST_THR_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tx_load |=> tx_busy && (thr_empty_ff || $past(wr_en && at(i_addr, ADR_HOLD) && !dlab)))
    else $error("transmit holding not taken");
  AST_LOOP_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    loop [*2] |-> o_serial_out && o_request_to_send_out_n && o_terminal_ready_out_n)
    else $error("loopback leaks to pins");
endmodule // suc_top

//--- hdl/suc_pkg.sv
// Functional notes
// - All logic runs on one free-running clock, rising edge only.
// - Baud clock is system clock divided by 16-bit divisor, then by 16.
// - Master reset loads the baud divisor with one.
// - Read data bus holds the last register read until the next read.
// - Transmitter and receiver handle 5, 6, 7 or 8 data bits.
// - Even, odd or no parity; generated on transmit, checked on receive.
// - Stop length of one, one and a half, or two bit times.
// - Receiver flags overrun, framing error, parity error and break.
// - Completed character goes to the receive holding register.
// - Transmit holding character is sent with start, parity (when enabled) and stop bits.
// - Interrupt on transmit empty, receive data, receive error, modem change.
// - Transmit, receive, line status and modem interrupts enable independently.
// - Interrupt identification register shows highest-priority pending source.
// - Separate in and out data buses plus a drive-disable output.
// - Address decoded directly on every access, no address latch.
// - Loopback mode ties transmit path to receive path internally.
package suc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int DIV_W  = 16;
  localparam int CNT_W  = 6;

  localparam logic [ADDR_W-1:0] ADR_HOLD       = 3'h0;
  localparam logic [ADDR_W-1:0] ADR_INT_EN     = 3'h1;
  localparam logic [ADDR_W-1:0] ADR_INT_ID     = 3'h2;
  localparam logic [ADDR_W-1:0] ADR_LINE_CTRL  = 3'h3;
  localparam logic [ADDR_W-1:0] ADR_MODEM_CTRL = 3'h4;
  localparam logic [ADDR_W-1:0] ADR_LINE_STAT  = 3'h5;
  localparam logic [ADDR_W-1:0] ADR_MODEM_STAT = 3'h6;
  localparam logic [ADDR_W-1:0] ADR_SCRATCH    = 3'h7;

  localparam logic [DIV_W-1:0]  DIV_RST  = 16'h0001;
  localparam logic [DATA_W-1:0] ZERO_8   = 8'h00;
  localparam logic [DATA_W-1:0] FULL_8   = 8'hff;
  localparam logic [1:0]        WLEN_MAX = 2'h3;
  localparam logic [3:0]        MIN_BITS = 4'h5;

  // Line control fields
  localparam int LC_STOP = 2;
  localparam int LC_PEN  = 3;
  localparam int LC_EVEN = 4;
  localparam int LC_STK  = 5;
  localparam int LC_BRK  = 6;
  localparam int LC_DLAB = 7;
  // Interrupt enable fields
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_LS = 2;
  localparam int IE_MS = 3;
  // Modem control fields
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;

  localparam logic [DATA_W-1:0] IID_NONE  = 8'h01;
  localparam logic [DATA_W-1:0] IID_LINE  = 8'h06;
  localparam logic [DATA_W-1:0] IID_RXDAT = 8'h04;
  localparam logic [DATA_W-1:0] IID_THRE  = 8'h02;
  localparam logic [DATA_W-1:0] IID_MODEM = 8'h00;

  localparam logic [CNT_W-1:0] TICKS_HALF = 6'h08;
  localparam logic [CNT_W-1:0] TICKS_BIT  = 6'h10;
  localparam logic [CNT_W-1:0] TICKS_1P5  = 6'h18;
  localparam logic [CNT_W-1:0] TICKS_2    = 6'h20;

  typedef enum logic [4:0] {
    SER_IDLE  = 5'b00001,
    SER_START = 5'b00010,
    SER_DATA  = 5'b00100,
    SER_PAR   = 5'b01000,
    SER_STOP  = 5'b10000
  } suc_ser_t;

  function automatic logic [2:0] last_bit(input logic [1:0] w);
    return 3'(MIN_BITS + 4'(w) - 4'h1);
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lcr);
    logic x;
    x = ^(d & (FULL_8 >> (WLEN_MAX - lcr[1:0])));
    if (lcr[LC_STK]) return !lcr[LC_EVEN];
    return lcr[LC_EVEN] ? x : !x;
  endfunction

  function automatic logic [CNT_W-1:0] stop_ticks(input logic [7:0] lcr);
    if (!lcr[LC_STOP]) return TICKS_BIT;
    return (lcr[1:0] == 2'h0) ? TICKS_1P5 : TICKS_2;
  endfunction
endpackage

//--- hdl/suc_baud.sv
`timescale 1ns/1ps
module suc_baud (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic [suc_pkg::DIV_W-1:0] i_divisor,
  output logic                           o_tick16,
  output logic                           o_baud_out
);
  import suc_pkg::*;
  logic [DIV_W-1:0] cnt_ff, nxt_cnt;
  logic [3:0]       sub_ff, nxt_sub;
  logic             tick_ff, nxt_tick;

  always_comb begin
    nxt_tick = (cnt_ff >= i_divisor - DIV_RST);
    nxt_cnt  = nxt_tick ? '0 : cnt_ff + DIV_RST;
    nxt_sub  = tick_ff ? sub_ff + 4'h1 : sub_ff;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_ff  <= '0;
      sub_ff  <= 4'h0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      sub_ff  <= nxt_sub;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick16   = tick_ff;
  assign o_baud_out = sub_ff[3];
endmodule // suc_baud

//--- hdl/suc_tx.sv
`timescale 1ns/1ps
module suc_tx (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_tick16,
  input  wire logic        i_load,
  input  wire logic [7:0]  i_data,
  input  wire logic [7:0]  i_lcr,
  output logic             o_txd,
  output logic             o_busy
);
  import suc_pkg::*;
  suc_ser_t          st_ff, nxt_st;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic [2:0]        bit_ff, nxt_bit;
  logic [7:0]        sh_ff, nxt_sh;
  logic              par_ff, nxt_par;
  logic              txd_ff, nxt_txd;
  logic              bit_end;

  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = i_tick16 ? cnt_ff + 6'h01 : cnt_ff;
    nxt_bit = bit_ff;
    nxt_sh  = sh_ff;
    nxt_par = par_ff;
    nxt_txd = 1'b1;
    bit_end = i_tick16 && (cnt_ff + 6'h01 == TICKS_BIT);
    case (st_ff)
      SER_IDLE: begin
        nxt_cnt = '0;
        if (i_load) begin
          nxt_sh  = i_data;
          nxt_par = par_bit(i_data, i_lcr);
          nxt_st  = SER_START;
          nxt_txd = 1'b0;
        end
      end
      SER_START: begin
        nxt_txd = 1'b0;
        if (bit_end) begin
          nxt_st  = SER_DATA;
          nxt_cnt = '0;
          nxt_bit = 3'h0;
          nxt_txd = sh_ff[0];
        end
      end
      SER_DATA: begin
        nxt_txd = sh_ff[0];
        if (bit_end) begin
          nxt_cnt = '0;
          nxt_sh  = sh_ff >> 1;
          nxt_bit = bit_ff + 3'h1;
          nxt_txd = sh_ff[1];
          if (bit_ff == last_bit(i_lcr[1:0])) begin
            nxt_st  = i_lcr[LC_PEN] ? SER_PAR : SER_STOP;
            nxt_txd = i_lcr[LC_PEN] ? par_ff : 1'b1;
          end
        end
      end
      SER_PAR: begin
        nxt_txd = par_ff;
        if (bit_end) begin
          nxt_st  = SER_STOP;
          nxt_cnt = '0;
          nxt_txd = 1'b1;
        end
      end
      SER_STOP: begin
        // Reaching or passing the count ends the stop, so a mid-stop length change cannot stall
        if (i_tick16 && (cnt_ff + 6'h01 >= stop_ticks(i_lcr))) begin
          nxt_st = SER_IDLE;
        end
      end
      default: nxt_st = SER_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff  <= SER_IDLE;
      cnt_ff <= '0;
      bit_ff <= 3'h0;
      sh_ff  <= ZERO_8;
      par_ff <= 1'b0;
      txd_ff <= 1'b1;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      sh_ff  <= nxt_sh;
      par_ff <= nxt_par;
      txd_ff <= nxt_txd;
    end
  end

  assign o_txd  = txd_ff;
  assign o_busy = (st_ff != SER_IDLE);
endmodule // suc_tx

//--- verif/suc_serial_peer.sv
`timescale 1ns/1ps
module suc_serial_peer (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  initial o_line = 1'b1;

  // Start low, lsb first, line back high after the frame
  task automatic send(input logic [11:0] bits, input int n, input int cyc);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_line <= bits[i];
      repeat (cyc - 1) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_line <= 1'b1;
  endtask

  // Mid-bit sampling from the falling start edge
  task automatic capture(input int n, input int cyc, output logic [11:0] bits);
    bits = 12'hfff;
    for (int t = 0; t < 4000 && i_line !== 1'b0; t++) @(posedge i_clk);
    repeat (cyc / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = i_line;
      repeat (cyc) @(posedge i_clk);
    end
  endtask
endmodule // suc_serial_peer

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import suc_pkg::*;
  logic              i_clk;
  logic              i_rst_n;
  logic              i_cs;
  logic              i_rd;
  logic              i_wr;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic [DATA_W-1:0] o_rdata;
  logic [DATA_W-1:0] v;
  logic              o_drive_disable_out;
  logic              o_irq;
  logic              ser_in;
  logic              cts_n;
  logic              o_serial_out;
  logic              o_baud_out;
  logic              o_request_to_send_out_n;
  logic              o_terminal_ready_out_n;
  logic [11:0]       got;
  logic [7:0]        cfg [3] = '{8'h03, 8'h1a, 8'h0c};
  logic [7:0]        dat [3] = '{8'ha5, 8'h5b, 8'h13};
  int                err_count;
  int                n_tests;
  int                t0;

  suc_top dut (
    .i_clk                   (i_clk),
    .i_rst_n                 (i_rst_n),
    .i_cs                    (i_cs),
    .i_rd                    (i_rd),
    .i_wr                    (i_wr),
    .i_addr                  (i_addr),
    .i_wdata                 (i_wdata),
    .o_rdata                 (o_rdata),
    .o_drive_disable_out     (o_drive_disable_out),
    .o_irq                   (o_irq),
    .i_serial_in             (ser_in),
    .o_serial_out            (o_serial_out),
    .o_baud_out              (o_baud_out),
    .i_clear_to_send_in_n    (cts_n),
    .i_peer_set_ready_in_n   (1'b1),
    .i_phone_call_alert_in_n (1'b1),
    .i_carrier_detect_in_n   (1'b1),
    .o_request_to_send_out_n (o_request_to_send_out_n),
    .o_terminal_ready_out_n  (o_terminal_ready_out_n)
  );

  suc_serial_peer peer (
    .i_clk  (i_clk),
    .i_line (o_serial_out),
    .o_line (ser_in)
  );

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_cs    <= 1'b1;
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_cs <= 1'b0;
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_cs   <= 1'b1;
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_cs <= 1'b0;
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask

  task automatic wait_dr(output logic [7:0] s);
    s = 8'h00;
    for (int k = 0; k < 300 && s[0] !== 1'b1; k++) rd(ADR_LINE_STAT, s);
    if (s[0] !== 1'b1) begin
      err_count++;
      $display("FAIL data_ready expected 1 seen %b", s[0]);
      wrap_up();
    end
  endtask

  task automatic edge_gap(output int n);
    logic prev;
    n = 0;
    do begin
      prev = o_baud_out;
      @(posedge i_clk);
      n++;
    end while (!(prev === 1'b0 && o_baud_out === 1'b1) && n < 300);
  endtask

  function automatic logic [11:0] mk_frame(input logic [7:0] lcr, input logic [7:0] d,
                                           input logic flip);
    logic [11:0] f;
    logic        p;
    int          nb;
    f    = 12'hfff;
    p    = 1'b0;
    nb   = 5 + lcr[1:0];
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) begin
      f[i+1] = d[i];
      p      = p ^ d[i];
    end
    if (lcr[3]) f[nb+1] = p ^ !lcr[4] ^ flip;
    return f;
  endfunction

  task automatic rx_case(input logic [7:0] lcr, input logic [11:0] f, input logic [7:0] d,
                         input logic [7:0] lsr);
    wr(ADR_LINE_CTRL, lcr);
    peer.send(f, 12, 16);
    wait_dr(v);
    chk("rx_status", lsr, v);
    rdc(ADR_HOLD, d, "rx_data");
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    err_count++;
    $display("FAIL watchdog expected finish seen hang");
    wrap_up();
  end

  initial begin
    err_count = 0;
    n_tests   = 0;
    i_rst_n   = 1'b0;
    i_cs      = 1'b0;
    i_rd      = 1'b0;
    i_wr      = 1'b0;
    i_addr    = '0;
    i_wdata   = '0;
    cts_n     = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rdc(ADR_LINE_STAT, 8'h60, "lsr_reset");
    chk("drive_disable_out_read", 1'b0, o_drive_disable_out);
    @(posedge i_clk);
    #1;
    chk("drive_disable_out_idle", 1'b1, o_drive_disable_out);
    rdc(ADR_INT_ID, IID_NONE, "iid_reset");
    wr(ADR_SCRATCH, 8'h5a);
    repeat (3) @(posedge i_clk);
    chk("rdata_hold", IID_NONE, o_rdata);
    rdc(ADR_SCRATCH, 8'h5a, "scratch");
    wr(ADR_LINE_CTRL, 8'h80);
    rdc(ADR_HOLD, 8'h01, "div_lo_reset");
    rdc(ADR_INT_EN, 8'h00, "div_hi_reset");
    foreach (cfg[i]) begin
      wr(ADR_LINE_CTRL, cfg[i]);
      wr(ADR_HOLD, dat[i]);
      peer.capture(7 + cfg[i][1:0] + cfg[i][3], 16, got);
      chk("tx_frame", mk_frame(cfg[i], dat[i], 1'b0), got);
    end
    rx_case(8'h03, mk_frame(8'h03, 8'h3c, 1'b0), 8'h3c, 8'h61);
    rx_case(8'h1a, mk_frame(8'h1a, 8'h4d, 1'b0), 8'h4d, 8'h61);
    rx_case(8'h1b, mk_frame(8'h1b, 8'hc3, 1'b1), 8'hc3, 8'h65);
    // Break frame: start, data and stop all low, then line back high
    rx_case(8'h03, 12'hc00, 8'h00, 8'h79);
    peer.send(mk_frame(8'h03, 8'h11, 1'b0), 12, 16);
    rx_case(8'h03, mk_frame(8'h03, 8'h22, 1'b0), 8'h22, 8'h63);
    wr(ADR_INT_EN, 8'h02);
    @(posedge i_clk);
    #1;
    chk("irq_thre", 1'b1, o_irq);
    rdc(ADR_INT_ID, IID_THRE, "iid_thre");
    rdc(ADR_INT_ID, IID_NONE, "iid_cleared");
    wr(ADR_INT_EN, 8'h05);
    wr(ADR_LINE_CTRL, 8'h1b);
    peer.send(mk_frame(8'h1b, 8'h81, 1'b1), 12, 16);
    chk("irq_err", 1'b1, o_irq);
    rdc(ADR_INT_ID, IID_LINE, "iid_line");
    rdc(ADR_LINE_STAT, 8'h65, "lsr_pe");
    rdc(ADR_INT_ID, IID_RXDAT, "iid_rx");
    rdc(ADR_HOLD, 8'h81, "rx_irq_data");
    rdc(ADR_INT_ID, IID_NONE, "iid_masked");
    chk("irq_off", 1'b0, o_irq);
    wr(ADR_INT_EN, 8'h08);
    cts_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    rdc(ADR_INT_ID, IID_MODEM, "iid_modem");
    rdc(ADR_MODEM_STAT, 8'h11, "msr_cts");
    rdc(ADR_INT_ID, IID_NONE, "iid_modem_clr");
    wr(ADR_MODEM_CTRL, 8'h13);
    wr(ADR_LINE_CTRL, 8'h03);
    wr(ADR_HOLD, 8'h96);
    wait_dr(v);
    chk("loop_line", 1'b1, o_serial_out);
    chk("loop_rts", 1'b1, o_request_to_send_out_n);
    chk("loop_dtr", 1'b1, o_terminal_ready_out_n);
    rdc(ADR_HOLD, 8'h96, "loop_data");
    wr(ADR_MODEM_CTRL, 8'h03);
    repeat (3) @(posedge i_clk);
    chk("rts_live", 1'b0, o_request_to_send_out_n);
    chk("dtr_live", 1'b0, o_terminal_ready_out_n);
    wr(ADR_LINE_CTRL, 8'h80);
    wr(ADR_HOLD, 8'h02);
    rdc(ADR_HOLD, 8'h02, "div_lo");
    wr(ADR_LINE_CTRL, 8'h03);
    edge_gap(t0);
    edge_gap(t0);
    chk("baud_period", 16'd32, t0[15:0]);
    wrap_up();
  end
endmodule // testbench
